// ==== hw/wdtu_counter.sv ====
// wdtu_counter.sv: free binary counter with period compare for the watchdog
// assumes: one clock, synchronous active-low reset, controls from the same clock domain
`timescale 1ns/10ps
`default_nettype none
`include "wdtu_defs.svh"

module wdtu_counter #(
  parameter int CNT_W = `WDTU_CNT_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             run_in,
  input  wire logic             zero_in,
  input  wire logic [2:0]       period_in,
  output logic                  expire_out,
  output logic [CNT_W-1:0]      count_out
);

  // terminal count for a period code: 2^(15 + 2*code) cycles
  function automatic logic [CNT_W:0] period_len(input logic [2:0] code);
    logic [CNT_W:0] len;
    len = '0;
    case (code)
      3'h0:    len = (CNT_W+1)'(1) << 15;
      3'h1:    len = (CNT_W+1)'(1) << 17;
      3'h2:    len = (CNT_W+1)'(1) << 19;
      3'h3:    len = (CNT_W+1)'(1) << 21;
      3'h4:    len = (CNT_W+1)'(1) << 23;
      3'h5:    len = (CNT_W+1)'(1) << 25;
      // prohibited codes behave as the longest period
      default: len = (CNT_W+1)'(1) << 25;
    endcase
    return len;
  endfunction : period_len

  logic [CNT_W:0] cnt_r;
  logic [CNT_W:0] cnt_nxt;
  logic           expire_r;

  assign cnt_nxt = cnt_r + (CNT_W+1)'(1);

  // up-counter; clear wins over counting
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (zero_in) begin
      cnt_r <= '0;
    end else if (run_in) begin
      // wraps to zero on expiry; >= so a period shortened below the count still expires
      cnt_r <= (cnt_nxt >= period_len(period_in)) ? '0 : cnt_nxt;
    end
  end

  // one-cycle pulse when the full period has been counted
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      expire_r <= 1'b0;
    end else begin
      expire_r <= run_in && !zero_in && (cnt_nxt >= period_len(period_in));
    end
  end

  assign expire_out = expire_r;
  assign count_out  = cnt_r[CNT_W-1:0];

endmodule : wdtu_counter

`default_nettype wire

// ==== hw/wdtu_defs.svh ====
// wdtu_defs.svh: offsets, field positions, reset values and timing counts for the watchdog
// assumes: included by bare name into the watchdog sources
`ifndef WDTU_DEFS_SVH
`define WDTU_DEFS_SVH

// register byte offsets on the wishbone bus
`define WDTU_OFS_MODE        4'h0
`define WDTU_OFS_CMD         4'h4
`define WDTU_OFS_STAT        4'h8
`define WDTU_OFS_MASK        4'hC

// mode register field positions
`define WDTU_MODE_EN_BIT     7
`define WDTU_MODE_PER_HI     6
`define WDTU_MODE_PER_LO     4
`define WDTU_MODE_IDLE_BIT   2
`define WDTU_MODE_ACT_BIT    1

// mode register reset fields
`define WDTU_RST_EN          1'b1
`define WDTU_RST_PER         3'h0
`define WDTU_RST_IDLE        1'b0
`define WDTU_RST_ACT         1'b1

// command codes
`define WDTU_CODE_DISABLE    8'hB1
`define WDTU_CODE_CLEAR      8'h4E

// event status bits
`define WDTU_EV_NMI_BIT      0
`define WDTU_EV_RST_BIT      1

// timing: internal reset length in system clock states
`define WDTU_RST_STATES      32
`define WDTU_CNT_W           25

`endif

// ==== hw/wdtu_pkg.sv ====
// wdtu_pkg.sv: types shared by the watchdog sources
// assumes: compiled before the modules that use it
package wdtu_pkg;

  // mode register fields as software sees them
  typedef struct packed {
    logic       enable;
    logic [2:0] period;
    logic       idle_run;
    logic       action;
  } wdtu_mode_t;

  // state of the internal reset pulse
  typedef enum logic [0:0] {
    WDTU_RST_IDLE_S,
    WDTU_RST_BUSY_S
  } wdtu_rst_state_t;

endpackage : wdtu_pkg

// ==== hw/wdtu_top.sv ====
// wdtu_top.sv: watchdog timeout unit with classic wishbone register slave
// assumes: one 25 MHz clock, synchronous active-low reset, idle/debug flags from same domain
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "wdtu_defs.svh"

module wdtu_top #(
  parameter int CNT_W = `WDTU_CNT_W
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // classic wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // processor state
  input  wire logic        idle_mode_in,
  input  wire logic        debug_mode_in,
  // timeout actions
  output logic             timeout_nmi_request_out,
  output logic             wdt_reset_out,
  output logic             irq_out
);

  wdtu_pkg::wdtu_mode_t       mode_r;
  wdtu_pkg::wdtu_rst_state_t  rst_state_r;
  logic                       running_r;
  logic [1:0]                 stat_r;
  logic [1:0]                 mask_r;
  logic [5:0]                 rst_cnt_r;
  logic                       nmi_r;
  logic                       wrst_r;
  logic                       irq_r;
  logic [31:0]                rdata_r;
  logic                       ack_r;

  logic                       wb_req;
  logic                       wr_mode;
  logic                       wr_cmd;
  logic                       wr_stat;
  logic                       wr_mask;
  logic                       cmd_disable;
  logic                       cmd_clear;
  logic                       cnt_run;
  logic                       cnt_zero;
  logic                       expire;
  logic [1:0]                 ev_set;

  // a new request is taken only while no ack is standing, so each access acks once
  assign wb_req  = wb_cyc_in && wb_stb_in && !ack_r;
  assign wr_mode = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == `WDTU_OFS_MODE);
  assign wr_cmd  = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == `WDTU_OFS_CMD);
  assign wr_stat = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == `WDTU_OFS_STAT);
  assign wr_mask = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == `WDTU_OFS_MASK);

  // command decode; enable bit must already be clear for the disable code
  assign cmd_disable = wr_cmd && (wb_dat_in[7:0] == `WDTU_CODE_DISABLE)
                       && !mode_r.enable;
  assign cmd_clear   = wr_cmd && (wb_dat_in[7:0] == `WDTU_CODE_CLEAR);

  // counting gate: run state set, not in debug, and idle only if idle-run set
  assign cnt_run  = running_r && !debug_mode_in
                    && (!idle_mode_in || mode_r.idle_run);
  assign cnt_zero = cmd_clear || cmd_disable;

  wdtu_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (cnt_run),
    .zero_in    (cnt_zero),
    .period_in  (mode_r.period),
    .expire_out (expire),
    .count_out  ()
  );

  // mode register; fields take write data on a byte-0 write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_r.enable   <= `WDTU_RST_EN;
      mode_r.period   <= `WDTU_RST_PER;
      mode_r.idle_run <= `WDTU_RST_IDLE;
      mode_r.action   <= `WDTU_RST_ACT;
    end else if (wr_mode) begin
      mode_r.enable   <= wb_dat_in[`WDTU_MODE_EN_BIT];
      mode_r.period   <= wb_dat_in[`WDTU_MODE_PER_HI:`WDTU_MODE_PER_LO];
      mode_r.idle_run <= wb_dat_in[`WDTU_MODE_IDLE_BIT];
      mode_r.action   <= wb_dat_in[`WDTU_MODE_ACT_BIT];
    end
  end

  // run state: clearing the enable bit alone keeps counting, guarding against stray writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      running_r <= 1'b1;
    end else if (cmd_disable) begin
      running_r <= 1'b0;
    end else if (wr_mode && wb_dat_in[`WDTU_MODE_EN_BIT]) begin
      running_r <= 1'b1;
    end
    // other command values fall through and change nothing
  end

  // timeout request: nmi level held until a clear or disable command, as the runaway pin would be
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nmi_r <= 1'b0;
    end else if (expire && !mode_r.action) begin
      nmi_r <= 1'b1;
    end else if (cmd_clear || cmd_disable) begin
      nmi_r <= 1'b0;
    end
  end

  // internal reset pulse of a fixed number of states
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rst_state_r <= wdtu_pkg::WDTU_RST_IDLE_S;
      rst_cnt_r   <= '0;
      wrst_r      <= 1'b0;
    end else begin
      case (rst_state_r)
        wdtu_pkg::WDTU_RST_IDLE_S: begin
          if (expire && mode_r.action) begin
            rst_state_r <= wdtu_pkg::WDTU_RST_BUSY_S;
            rst_cnt_r   <= 6'(`WDTU_RST_STATES - 1);
            wrst_r      <= 1'b1;
          end
        end
        wdtu_pkg::WDTU_RST_BUSY_S: begin
          if (rst_cnt_r == 6'h00) begin
            rst_state_r <= wdtu_pkg::WDTU_RST_IDLE_S;
            wrst_r      <= 1'b0;
          end else begin
            rst_cnt_r <= rst_cnt_r - 6'h01;
          end
        end
        default: begin
          rst_state_r <= wdtu_pkg::WDTU_RST_IDLE_S;
          wrst_r      <= 1'b0;
        end
      endcase
    end
  end

  // sticky event bits; a new event beats a write-one clear in the same cycle
  assign ev_set[`WDTU_EV_NMI_BIT] = expire && !mode_r.action;
  assign ev_set[`WDTU_EV_RST_BIT] = expire && mode_r.action;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? wb_dat_in[1:0] : 2'h0)) | ev_set;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= wb_dat_in[1:0];
    end
  end

  // maskable summary interrupt, registered for a clean output
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((stat_r & ~(wr_stat ? wb_dat_in[1:0] : 2'h0) | ev_set) & mask_r);
    end
  end

  // bus answer: one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r   <= wb_req;
      rdata_r <= '0;
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          `WDTU_OFS_MODE: begin
            rdata_r[`WDTU_MODE_EN_BIT]                    <= mode_r.enable;
            rdata_r[`WDTU_MODE_PER_HI:`WDTU_MODE_PER_LO]  <= mode_r.period;
            rdata_r[`WDTU_MODE_IDLE_BIT]                  <= mode_r.idle_run;
            rdata_r[`WDTU_MODE_ACT_BIT]                   <= mode_r.action;
          end
          `WDTU_OFS_STAT: rdata_r[1:0] <= stat_r;
          `WDTU_OFS_MASK: rdata_r[1:0] <= mask_r;
          // command register and unmapped words read as zero
          default:        rdata_r      <= '0;
        endcase
      end
    end
  end

  assign wb_ack_out              = ack_r;
  assign wb_dat_out              = rdata_r;
  assign timeout_nmi_request_out = nmi_r;
  assign wdt_reset_out           = wrst_r;
  assign irq_out                 = irq_r;

endmodule : wdtu_top

`default_nettype wire

// ==== tb/tb.sv ====
// tb.sv: self-checking bench for the watchdog timeout unit
// assumes: design, checker and reset sink compiled before it
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic        idle_mode_in, debug_mode_in, timeout_nmi_request_out, wdt_reset_out, irq_out;
  logic [3:0]  wb_adr_in, wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic [7:0]  width;
  logic [15:0] lf;
  int          fails, compares, n_dbg, n_idl, gap, want;

  wdtu_top u_dut (.clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .idle_mode_in, .debug_mode_in,
    .timeout_nmi_request_out, .wdt_reset_out, .irq_out);
  wdtu_reset_sink u_sink (.clk_in, .rst_n_in, .wdt_reset_in(wdt_reset_out), .width_out(width));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // mode word as it must read back
  function automatic logic [31:0] mode_w(input logic e, input logic [2:0] p, input logic i,
                                         input logic a);
    return {24'h00_0000, e, p, 1'b0, i, a, 1'b0};
  endfunction : mode_w

  // cycles to expiry: full period plus frozen cycles
  function automatic int expiry(input int code, input int frozen);
    return (1 << (15 + 2 * code)) + frozen;
  endfunction : expiry

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} <= {2'h3, we, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'h0;
    if (n >= 20) begin
      fails++;
      test_done();
    end
  endtask : wb

  // edges until a flag rises; debug then idle held for the given stretches
  task automatic wait_rise(ref logic f, input int dbg, input int idl);
    gap = 0;
    while (f !== 1'b1 && gap < 40000) begin
      @(posedge clk_in);
      gap++;
      debug_mode_in <= (gap >= 10 && gap < 10 + dbg);
      idle_mode_in  <= (gap >= 20 + dbg && gap < 20 + dbg + idl);
    end
    if (gap >= 40000) begin
      fails++;
      test_done();
    end
  endtask : wait_rise

  initial begin
    {fails, compares, lf} = {32'h0, 32'h0, 16'h2224};
    {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, idle_mode_in, debug_mode_in} = 6'h00;
    {wb_adr_in, wb_sel_in, wb_dat_in} = 40'h00_0000_0000;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wb(1'b0, 4'h0, 0); check("mode", rd, mode_w(1, 3'h0, 0, 1));
    wb(1'b0, 4'h4, 0); check("command", rd, 0);
    wb(1'b0, 4'h2, 0); check("hole", rd, 0);
    for (int p = 0; p < 6; p++) begin
      lf = lfsr(lf);
      wb(1'b1, 4'h0, {lf, 8'h80 | {1'b0, p[2:0], lf[3], lf[0], 2'h2}});
      wb(1'b0, 4'h0, 0); check("mode fields", rd, mode_w(1, p[2:0], lf[0], 1));
    end
    $display("registers done");
    // nmi action; idle-run off, so idle freezes like debug
    wb(1'b1, 4'hC, 32'h0000_0001);
    wb(1'b1, 4'h0, mode_w(1, 3'h0, 0, 0));
    lf = lfsr(lf);
    n_dbg = 100 + lf[5:0];
    lf = lfsr(lf);
    n_idl = 100 + lf[5:0];
    wb(1'b1, 4'h4, 32'h0000_004E);
    wait_rise(timeout_nmi_request_out, n_dbg, n_idl);
    want = expiry(0, n_dbg + n_idl);
    check("nmi delay", gap inside {[want - 4 : want + 4]}, 1);
    check("reset with nmi", wdt_reset_out, 0);
    wb(1'b0, 4'h8, 0); check("status", rd, 1);
    check("irq", irq_out, 1);
    wb(1'b1, 4'h4, 32'h0000_005A); check("nmi kept", timeout_nmi_request_out, 1);
    wb(1'b1, 4'h4, 32'h0000_004E); check("nmi cleared", timeout_nmi_request_out, 0);
    wb(1'b1, 4'h8, 32'h0000_0001);
    wb(1'b0, 4'h8, 0); check("status clear", rd, 0);
    check("irq clear", irq_out, 0);
    $display("nmi done");
    // two-step disable, a dead gap, then re-enable with reset action and idle-run on
    wb(1'b1, 4'h0, mode_w(0, 3'h0, 1, 1));
    wb(1'b1, 4'h4, 32'h0000_00B1);
    repeat (300) @(posedge clk_in);
    wb(1'b1, 4'h0, mode_w(1, 3'h0, 1, 1));
    wait_rise(wdt_reset_out, 0, n_idl);
    check("reset delay", gap inside {[expiry(0, 0) - 4 : expiry(0, 0) + 4]}, 1);
    repeat (40) @(posedge clk_in);
    check("reset width", width, 32);
    check("nmi on reset", timeout_nmi_request_out, 0);
    wb(1'b0, 4'h8, 0); check("status", rd, 2);
    check("irq masked", irq_out, 0);
    $display("reset done");
    test_done();
  end
endmodule : tb

bind wdtu_top wdtu_checker u_chk (.clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .debug_mode_in,
  .timeout_nmi_request_out, .wdt_reset_out);
`default_nettype wire

// ==== tb/wdtu_checker.sv ====
// wdtu_checker.sv: port timing checks for the watchdog
// assumes: bound to wdtu_top; one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module wdtu_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [3:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        debug_mode_in,
  input wire logic        timeout_nmi_request_out,
  input wire logic        wdt_reset_out
);
  logic        take;
  logic        cmd_wr;
  logic [5:0]  len_r;
  logic [15:0] age_r;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // request taken at this edge; command byte write
  assign take   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign cmd_wr = take && wb_we_in && wb_adr_in == 4'h4 && wb_sel_in[0];

  // pulse length, and age since reset saturating so it never wraps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      len_r <= 6'h00;
      age_r <= 16'h0000;
    end else begin
      len_r <= wdt_reset_out ? len_r + 6'h01 : 6'h00;
      age_r <= (&age_r) ? age_r : age_r + 16'h0001;
    end
  end

  a_ack_follows: assert property (take |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_data_quiet: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  a_cmd_reads_zero: assert property (take && !wb_we_in && wb_adr_in == 4'h4
    |=> wb_dat_out == 32'h0000_0000) else $error("command read not zero");
  a_nmi_held: assert property (timeout_nmi_request_out &&
    !(cmd_wr && (wb_dat_in[7:0] == 8'h4E || wb_dat_in[7:0] == 8'hB1))
    |=> timeout_nmi_request_out) else $error("nmi dropped on its own");
  a_clear_drops: assert property (cmd_wr && wb_dat_in[7:0] == 8'h4E
    |-> ##[1:2] !timeout_nmi_request_out) else $error("clear kept nmi");
  a_reset_len: assert property ($fell(wdt_reset_out) |-> len_r == 6'h20)
    else $error("reset pulse length wrong");
  a_reset_cap: assert property (len_r <= 6'h20)
    else $error("reset pulse too long");
  a_one_action: assert property ($rose(wdt_reset_out) |-> !$rose(timeout_nmi_request_out))
    else $error("both actions at once");
  a_debug_frozen: assert property ($rose(timeout_nmi_request_out) |->
    !($past(debug_mode_in, 1) && $past(debug_mode_in, 2) && $past(debug_mode_in, 3)))
    else $error("timeout during debug");
  a_no_early: assert property (age_r < 16'h7D00 |->
    !timeout_nmi_request_out && !wdt_reset_out) else $error("timeout too early");
endmodule : wdtu_checker
`default_nettype wire

// ==== tb/wdtu_reset_sink.sv ====
// wdtu_reset_sink.sv: far-side model of the reset logic
// assumes: same clock as the watchdog; measures each internal reset pulse
`timescale 1ns/10ps
`default_nettype none

module wdtu_reset_sink (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wdt_reset_in,
  output logic [7:0]      width_out
);
  logic [7:0] run_r;

  // not looped back to reset, so the bench survives a pulse and can judge it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_r     <= 8'h00;
      width_out <= 8'h00;
    end else if (wdt_reset_in) begin
      run_r <= run_r + 8'h01;
    end else if (run_r != 8'h00) begin
      width_out <= run_r;
      run_r     <= 8'h00;
    end
  end
endmodule : wdtu_reset_sink
`default_nettype wire
